// *** core/rct_consts.svh ***
// Purpose: Named offsets, field positions, reset values and rates of the reload timer
// Assumes: Included by the package and by the timer module
// Notes:   Definitions only
`ifndef RCT_CONSTS_SVH
`define RCT_CONSTS_SVH

// Register offsets on the byte-wide register port
`define RCT_ADDR_T2_RELOAD_LO 8'h1b
`define RCT_ADDR_T2_COUNT_HI  8'h1c
`define RCT_ADDR_T2_COUNT_LO  8'h1d
`define RCT_ADDR_T3_CONTROL   8'h1e
`define RCT_ADDR_T3_RELOAD_HI 8'h1f
`define RCT_ADDR_IRQ_STATUS   8'h30
`define RCT_ADDR_IRQ_MASK     8'h31

// Field positions in the timer3 control byte
`define RCT_T3_STOP_RX_BIT    3'h7
`define RCT_T3_START_HI_BIT   3'h5
`define RCT_T3_START_LO_BIT   3'h4
`define RCT_T3_AUTO_BIT       3'h3
`define RCT_T3_CLK_HI_BIT     3'h1
`define RCT_T3_CLK_LO_BIT     3'h0
`define RCT_T3_CTRL_WMASK     8'hbb

// Interrupt status and mask layout
`define RCT_IRQ_T2_BIT        1'h0
`define RCT_IRQ_T3_BIT        1'h1
`define RCT_IRQ_WIDTH         2

// Reset values
`define RCT_BYTE_RESET        8'h00
`define RCT_COUNT_RESET       16'h0000
`define RCT_IRQ_RESET         2'h0

// Rates: system clock 200 MHz, carrier tick 13.56 MHz, slow tick carrier / 64
`define RCT_SYS_CLK_HZ        28'hbebc200
`define RCT_CARRIER_HZ        28'h0cee8c0
`define RCT_SLOW_DIV_LAST     6'h3f

`endif

// *** core/rct_pkg.sv ***
// Purpose: Types shared by the reload countdown timer
// Assumes: Constants come from rct_consts.svh
// Notes:   State of the timer module is one packed struct
`include "rct_consts.svh"

package rct_pkg;

  // Register port request, one cycle per access
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rct_bus_req_type;

  // Automatic start and trimming modes of timer3
  typedef enum logic [1:0] {
    RCT_START_OFF      = 2'h0,
    RCT_START_TX_END   = 2'h1,
    RCT_START_TRIM     = 2'h2,
    RCT_START_TRIM_UNF = 2'h3
  } rct_start_mode_type;

  // Input clock choice of timer3
  typedef enum logic [1:0] {
    RCT_CLK_CARRIER = 2'h0,
    RCT_CLK_SLOW    = 2'h1,
    RCT_CLK_T0_UNF  = 2'h2,
    RCT_CLK_T1_UNF  = 2'h3
  } rct_clk_sel_type;

  // Timer3 run state, Gray coded along idle -> run -> trim
  typedef enum logic [1:0] {
    RCT_T3_IDLE = 2'h0,
    RCT_T3_RUN  = 2'h1,
    RCT_T3_TRIM = 2'h3
  } rct_t3_state_type;

  // Complete register state of the timer module
  typedef struct packed {
    logic [7:0]                 t2_reload_lo;
    logic [15:0]                t2_count;
    logic                       t2_run;
    logic                       t2_unf;
    logic [7:0]                 t3_ctrl;
    logic [7:0]                 t3_reload_hi;
    logic [15:0]                t3_count;
    rct_t3_state_type           t3_state;
    logic                       t3_unf;
    logic [27:0]                acc;
    logic                       fast_tick;
    logic                       slow_tick;
    logic [5:0]                 slow_div;
    logic [2:0]                 lfo_sync;
    logic                       lfo_level;
    logic [`RCT_IRQ_WIDTH-1:0]  irq_status;
    logic [`RCT_IRQ_WIDTH-1:0]  irq_mask;
    logic                       irq;
    logic [7:0]                 rdata;
  } rct_state_type;

endpackage : rct_pkg

// *** core/rct_timer.sv ***
// Purpose: Timer2 reload/readback bytes and the complete timer3 countdown unit
// Assumes: One 200 MHz clock; timer2 control and timer3 low reload byte live elsewhere
// Notes:   Byte register port, read data one cycle after the read strobe
//
// Functional notes
// - Timer2 start loads counter from both reload bytes
// - Timer2 high reload byte forms counter bits 15..8
// - Timer3 start loads high and low reload bytes
// - Reload writes act only at next start or timer3 auto reload
// - Timer2 live count readable, high then low
// - Stop-on-receive halts timer3 after four bits
// - Stop-on-receive ignored in trimming modes
// - Start mode 00 none, 01 at transmit end
// - Modes 10/11 trim on oscillator rising edges
// - Auto reload restarts countdown after zero, except in start mode 10
// - Without auto reload timer3 stops at zero, except in start mode 10
// - Each timer3 underflow sets interrupt flag
// - Clock select 00 carrier, 01 slow rate
// - Clock select 10/11 cascade timer0/timer1 underflow
`timescale 1ns/100ps
`include "rct_consts.svh"

module rct_timer
  import rct_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rst_b_in,
  input  wire rct_bus_req_type reg_req_in,
  output logic [7:0]           reg_rdata_out,
  input  wire logic [7:0]      timer2_reload_high_value_in,
  input  wire logic            timer2_start_in,
  input  wire logic            timer2_stop_in,
  input  wire logic            timer2_tick_in,
  input  wire logic [7:0]      timer3_reload_low_value_in,
  input  wire logic            timer3_start_in,
  input  wire logic            timer3_stop_in,
  input  wire logic            tx_end_in,
  input  wire logic            rx_nibble_done_in,
  input  wire logic            timer0_underflow_in,
  input  wire logic            timer1_underflow_in,
  input  wire logic            low_frequency_oscillator_in,
  output logic                 timer2_underflow_out,
  output logic                 timer3_underflow_out,
  output logic [15:0]          timer3_count_out,
  output logic                 timer3_running_out,
  output logic                 irq_out
);

  rct_state_type q;
  rct_state_type d;

  // Address match for one access kind
  function automatic logic rct_hit(input rct_bus_req_type req,
                                   input logic            strobe,
                                   input logic [7:0]      addr);
    rct_hit = strobe && (req.addr == addr);
  endfunction : rct_hit

  // Readback byte for an address, zero where nothing is mapped
  function automatic logic [7:0] rct_read(input rct_state_type s, input logic [7:0] addr);
    logic [7:0] v;
    v = `RCT_BYTE_RESET;
    case (addr)
      `RCT_ADDR_T2_RELOAD_LO: v = s.t2_reload_lo;
      `RCT_ADDR_T2_COUNT_HI:  v = s.t2_count[15:8];
      `RCT_ADDR_T2_COUNT_LO:  v = s.t2_count[7:0];
      `RCT_ADDR_T3_CONTROL:   v = s.t3_ctrl & `RCT_T3_CTRL_WMASK;
      `RCT_ADDR_T3_RELOAD_HI: v = s.t3_reload_hi;
      `RCT_ADDR_IRQ_STATUS:   v = {6'h00, s.irq_status};
      `RCT_ADDR_IRQ_MASK:     v = {6'h00, s.irq_mask};
      default:                v = `RCT_BYTE_RESET;
    endcase
    rct_read = v;
  endfunction : rct_read

  // Working signals of the next-state process
  rct_start_mode_type start_mode;
  rct_clk_sel_type    clk_sel;
  logic               trim_mode;
  logic               t3_running;
  logic               t3_tick;
  logic               t3_start;
  logic               t3_stop;
  logic               lfo_rise;
  logic               t3_unf_event;
  logic [15:0]        t3_reload;
  logic [27:0]        acc_sum;
  logic [7:0]         status_clear;

  // Next-state computation for the whole block
  always_comb begin
    d            = q;
    start_mode   = rct_start_mode_type'(q.t3_ctrl[`RCT_T3_START_HI_BIT:`RCT_T3_START_LO_BIT]);
    clk_sel      = rct_clk_sel_type'(q.t3_ctrl[`RCT_T3_CLK_HI_BIT:`RCT_T3_CLK_LO_BIT]);
    trim_mode    = start_mode[1];
    t3_running   = (q.t3_state != RCT_T3_IDLE);
    t3_reload    = {q.t3_reload_hi, timer3_reload_low_value_in};
    t3_unf_event = 1'b0;
    status_clear = `RCT_BYTE_RESET;

    // Carrier tick by phase accumulation, slow tick is carrier / 64
    acc_sum     = q.acc + `RCT_CARRIER_HZ;
    d.fast_tick = 1'b0;
    d.slow_tick = 1'b0;
    if (acc_sum >= `RCT_SYS_CLK_HZ) begin
      d.acc       = acc_sum - `RCT_SYS_CLK_HZ;
      d.fast_tick = 1'b1;
      d.slow_div  = q.slow_div + 6'h01;
      d.slow_tick = (q.slow_div == `RCT_SLOW_DIV_LAST);
    end else begin
      d.acc = acc_sum;
    end

    // Oscillator pin: three stages, level moves once stages two and three agree
    d.lfo_sync = {q.lfo_sync[1:0], low_frequency_oscillator_in};
    if (q.lfo_sync[1] == q.lfo_sync[2]) begin
      d.lfo_level = q.lfo_sync[2];
    end
    lfo_rise = !q.lfo_level && (q.lfo_sync[1] == q.lfo_sync[2]) && q.lfo_sync[2];

    // Register writes; reload bytes only feed the next start or timer3 auto reload
    if (rct_hit(reg_req_in, reg_req_in.wr, `RCT_ADDR_T2_RELOAD_LO)) begin
      d.t2_reload_lo = reg_req_in.wdata;
    end
    if (rct_hit(reg_req_in, reg_req_in.wr, `RCT_ADDR_T3_CONTROL)) begin
      d.t3_ctrl = reg_req_in.wdata & `RCT_T3_CTRL_WMASK;
    end
    if (rct_hit(reg_req_in, reg_req_in.wr, `RCT_ADDR_T3_RELOAD_HI)) begin
      d.t3_reload_hi = reg_req_in.wdata;
    end
    if (rct_hit(reg_req_in, reg_req_in.wr, `RCT_ADDR_IRQ_MASK)) begin
      d.irq_mask = reg_req_in.wdata[`RCT_IRQ_WIDTH-1:0];
    end
    if (rct_hit(reg_req_in, reg_req_in.wr, `RCT_ADDR_IRQ_STATUS)) begin
      status_clear = reg_req_in.wdata;
    end

    // Timer2: load on start, count down on its tick, stop at underflow
    d.t2_unf = 1'b0;
    if (timer2_start_in) begin
      d.t2_count = {timer2_reload_high_value_in, q.t2_reload_lo};
      d.t2_run   = 1'b1;
    end else if (timer2_stop_in) begin
      d.t2_run = 1'b0;
    end else if (q.t2_run && timer2_tick_in) begin
      if (q.t2_count == `RCT_COUNT_RESET) begin
        d.t2_unf = 1'b1;
        d.t2_run = 1'b0;
      end else begin
        d.t2_count = q.t2_count - 16'h0001;
      end
    end

    // Timer3 input clock choice
    unique case (clk_sel)
      RCT_CLK_CARRIER: t3_tick = q.fast_tick;
      RCT_CLK_SLOW:    t3_tick = q.slow_tick;
      RCT_CLK_T0_UNF:  t3_tick = timer0_underflow_in;
      RCT_CLK_T1_UNF:  t3_tick = timer1_underflow_in;
    endcase

    // Timer3 start and stop events
    t3_start = timer3_start_in
             || ((start_mode == RCT_START_TX_END) && tx_end_in)
             || (trim_mode && lfo_rise && !t3_running);
    t3_stop  = timer3_stop_in
             || (trim_mode && lfo_rise && t3_running)
             || (!trim_mode && q.t3_ctrl[`RCT_T3_STOP_RX_BIT]
                 && rx_nibble_done_in);

    // Timer3 run state and counter; start wins over stop
    d.t3_unf = 1'b0;
    if (t3_start) begin
      d.t3_count = t3_reload;
      d.t3_state = trim_mode ? RCT_T3_TRIM : RCT_T3_RUN;
    end else if (t3_stop) begin
      d.t3_state = RCT_T3_IDLE;
    end else if (t3_running && t3_tick) begin
      if (q.t3_count != `RCT_COUNT_RESET) begin
        d.t3_count = q.t3_count - 16'h0001;
      end else if (start_mode != RCT_START_TRIM) begin
        t3_unf_event = 1'b1;
        d.t3_unf     = 1'b1;
        if (q.t3_ctrl[`RCT_T3_AUTO_BIT]) begin
          d.t3_count = t3_reload;
        end else begin
          d.t3_state = RCT_T3_IDLE;
        end
      end
    end
    unique case (d.t3_state)
      RCT_T3_IDLE: d.t3_state = RCT_T3_IDLE;
      RCT_T3_RUN:  d.t3_state = RCT_T3_RUN;
      RCT_T3_TRIM: d.t3_state = RCT_T3_TRIM;
      default:     d.t3_state = RCT_T3_IDLE;
    endcase

    // Sticky interrupt bits: a new event beats a clear in the same cycle
    d.irq_status = (q.irq_status & ~status_clear[`RCT_IRQ_WIDTH-1:0])
                 | {t3_unf_event, d.t2_unf};
    d.irq        = |(d.irq_status & d.irq_mask);

    // Read data stands in the cycle after the read strobe
    d.rdata = reg_req_in.rd ? rct_read(q, reg_req_in.addr) : `RCT_BYTE_RESET;
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      q.t2_reload_lo <= `RCT_BYTE_RESET;
      q.t2_count     <= `RCT_COUNT_RESET;
      q.t2_run       <= 1'b0;
      q.t2_unf       <= 1'b0;
      q.t3_ctrl      <= `RCT_BYTE_RESET;
      q.t3_reload_hi <= `RCT_BYTE_RESET;
      q.t3_count     <= `RCT_COUNT_RESET;
      q.t3_state     <= RCT_T3_IDLE;
      q.t3_unf       <= 1'b0;
      q.acc          <= 28'h0000000;
      q.fast_tick    <= 1'b0;
      q.slow_tick    <= 1'b0;
      q.slow_div     <= 6'h00;
      q.lfo_sync     <= 3'h0;
      q.lfo_level    <= 1'b0;
      q.irq_status   <= `RCT_IRQ_RESET;
      q.irq_mask     <= `RCT_IRQ_RESET;
      q.irq          <= 1'b0;
      q.rdata        <= `RCT_BYTE_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata_out        = q.rdata;
  assign timer2_underflow_out = q.t2_unf;
  assign timer3_underflow_out = q.t3_unf;
  assign timer3_count_out     = q.t3_count;
  assign timer3_running_out   = q.t3_state[0];  // Low state bit is set in both run codes
  assign irq_out              = q.irq;

endmodule : rct_timer

// *** testbench/rct_timer_chk.sv ***
// Purpose: Port assertions for the timer3 unit and register port
// Assumes: Shadows follow writes to control, reload high and mask
// Notes:   Attached by bind below
`timescale 1ns/100ps
module rct_timer_chk
  import rct_pkg::*;
(
  input  wire logic            clk_in,
  input  wire logic            rst_b_in,
  input  wire rct_bus_req_type reg_req_in,
  input  wire logic [7:0]      reg_rdata_out,
  input  wire logic [7:0]      timer3_reload_low_value_in,
  input  wire logic            timer3_start_in,
  input  wire logic            timer3_stop_in,
  input  wire logic            tx_end_in,
  input  wire logic            rx_nibble_done_in,
  input  wire logic            timer0_underflow_in,
  input  wire logic            timer3_underflow_out,
  input  wire logic [15:0]     timer3_count_out,
  input  wire logic            timer3_running_out,
  input  wire logic            irq_out
);
  logic [7:0] ctrl_q;
  logic [7:0] hi_q;
  logic       msk_q;
  logic       quiet;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // No start, stop, transmit-end or receive pulse this cycle
  assign quiet = !timer3_start_in && !timer3_stop_in && !tx_end_in && !rx_nibble_done_in;
  // Shadows of the written bytes
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_q <= 8'h00;
      hi_q   <= 8'h00;
      msk_q  <= 1'b0;
    end else if (reg_req_in.wr) begin
      if (reg_req_in.addr == 8'h1e) ctrl_q <= reg_req_in.wdata;
      if (reg_req_in.addr == 8'h1f) hi_q <= reg_req_in.wdata;
      if (reg_req_in.addr == 8'h31) msk_q <= reg_req_in.wdata[1];
    end
  end
  chk_rdata_idle: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 8'h00)
    else $error("read data outside read slot");
  chk_ctrl_reserved: assert property ($past(reg_req_in.rd) && $past(reg_req_in.addr) == 8'h1e
    |-> (reg_rdata_out & 8'h44) == 8'h00) else $error("reserved bits set");
  chk_start_load: assert property (timer3_start_in && !reg_req_in.wr |=> timer3_running_out &&
    timer3_count_out == {$past(hi_q), $past(timer3_reload_low_value_in)})
    else $error("start load wrong");
  chk_auto_reload: assert property (timer3_underflow_out && ctrl_q[3] |->
    timer3_running_out && timer3_count_out == {hi_q, timer3_reload_low_value_in})
    else $error("no reload after zero");
  chk_zero_stop: assert property (timer3_underflow_out && !ctrl_q[3] |-> !timer3_running_out)
    else $error("kept running at zero");
  chk_flag_irq: assert property (timer3_underflow_out && msk_q |-> ##[0:1] irq_out)
    else $error("underflow gave no interrupt");
  chk_rx_stop: assert property (rx_nibble_done_in && ctrl_q[7] && !ctrl_q[5] && !tx_end_in
    && !timer3_start_in |=> !timer3_running_out) else $error("no stop on receive");
  chk_tx_start: assert property (tx_end_in && ctrl_q[5:4] == 2'h1 |=> timer3_running_out)
    else $error("no start at transmit end");
  chk_cascade_tick: assert property (timer3_running_out && ctrl_q[1:0] == 2'h2 && quiet
    && timer0_underflow_in && timer3_count_out != 16'h0000
    |=> timer3_count_out == $past(timer3_count_out) - 16'h0001) else $error("cascade miss");
  // Main scenarios reached
  cov_underflow: cover property (timer3_underflow_out);
  cov_irq: cover property (irq_out);
  cov_rx_stop: cover property (rx_nibble_done_in && timer3_running_out);
endmodule : rct_timer_chk

bind rct_timer rct_timer_chk u_chk (.clk_in, .rst_b_in, .reg_req_in, .reg_rdata_out,
  .timer3_reload_low_value_in, .timer3_start_in, .timer3_stop_in, .tx_end_in,
  .rx_nibble_done_in, .timer0_underflow_in, .timer3_underflow_out, .timer3_count_out,
  .timer3_running_out, .irq_out);

// *** testbench/reload_countdown_timer_test.sv ***
// Purpose: Register and event sequences for rct_timer
// Assumes: Interrupt bit1 is the timer3 underflow
// Notes:   Events are one-cycle pulses
`timescale 1ns/100ps
module reload_countdown_timer_test import rct_pkg::*;;
  logic            clk_in;
  logic            rst_b_in;
  rct_bus_req_type req;
  logic [7:0]      rdata;
  logic [8:0]      ev;
  logic            low_frequency_oscillator;
  logic            t3_unf;
  logic            t2_unf;
  logic [7:0]      t2_hi;
  logic            t3_run;
  logic            irq;
  logic [15:0]     t3_cnt;
  int              fail_count;
  int              num_checks;
  rct_timer dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .timer2_reload_high_value_in(t2_hi), .timer2_start_in(ev[0]),
    .timer2_stop_in(ev[1]), .timer2_tick_in(ev[2]), .timer3_reload_low_value_in(8'h02),
    .timer3_start_in(ev[3]), .timer3_stop_in(ev[4]), .tx_end_in(ev[5]),
    .rx_nibble_done_in(ev[6]), .timer0_underflow_in(ev[7]), .timer1_underflow_in(ev[8]),
    .low_frequency_oscillator_in(low_frequency_oscillator), .timer2_underflow_out(t2_unf),
    .timer3_underflow_out(t3_unf),
    .timer3_count_out(t3_cnt), .timer3_running_out(t3_run), .irq_out(irq));
  // Clock
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, exp});
  endtask : rd
  task automatic pulse(input int b);
    @(posedge clk_in);
    ev <= 9'h001 << b;
    @(posedge clk_in);
    ev <= 9'h000;
    #1;
  endtask : pulse
  task automatic wait_run(input logic lvl, input int n);
    #1;
    for (int i = 0; i < n && t3_run !== lvl; i++) begin
      @(posedge clk_in);
      #1;
    end
    chk({15'h0, t3_run}, {15'h0, lvl});
    if (t3_run !== lvl) end_of_test();
  endtask : wait_run
  // Main sequence
  initial begin
    rst_b_in = 1'b0;
    req = '0;
    ev = '0;
    low_frequency_oscillator = 1'b0;
    t2_hi = 8'h3c;
    fail_count = 0;
    num_checks = 0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int a = 8'h1b; a <= 8'h1f; a++) rd(8'(a), 8'h00);
    wr(8'h1e, 8'hff);
    rd(8'h1e, 8'hbb);
    rd(8'h40, 8'h00);
    wr(8'h1b, 8'h02);
    rd(8'h1b, 8'h02);
    pulse(0);
    rd(8'h1c, 8'h3c);
    rd(8'h1d, 8'h02);
    wr(8'h1b, 8'h77);
    pulse(2);
    rd(8'h1d, 8'h01);
    pulse(0);
    rd(8'h1d, 8'h77);
    wr(8'h1c, 8'h55);
    rd(8'h1c, 8'h3c);
    // Timer2 runs down to underflow from a new high byte
    @(posedge clk_in);
    t2_hi <= 8'h00;
    wr(8'h1b, 8'h01);
    pulse(0);
    rd(8'h1c, 8'h00);
    pulse(2);
    pulse(2);
    chk({15'h0, t2_unf}, 16'h0001);
    rd(8'h30, 8'h01);
    wr(8'h30, 8'h01);
    rd(8'h30, 8'h00);
    // Timer3 cascade on timer0 with auto reload
    wr(8'h1f, 8'h00);
    wr(8'h31, 8'h02);
    wr(8'h1e, 8'h0a);
    pulse(3);
    chk(t3_cnt, 16'h0002);
    repeat (2) pulse(7);
    chk(t3_cnt, 16'h0000);
    pulse(7);
    chk({15'h0, t3_unf}, 16'h0001);
    chk(t3_cnt, 16'h0002);
    rd(8'h30, 8'h02);
    chk({15'h0, irq}, 16'h0001);
    wr(8'h30, 8'h02);
    rd(8'h30, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    // Timer1 cascade, no auto reload, interrupt masked
    wr(8'h31, 8'h00);
    wr(8'h1e, 8'h03);
    pulse(3);
    pulse(7);
    chk(t3_cnt, 16'h0002);
    repeat (3) pulse(8);
    chk({15'h0, t3_run}, 16'h0000);
    rd(8'h30, 8'h02);
    chk({15'h0, irq}, 16'h0000);
    wr(8'h31, 8'h02);
    rd(8'h31, 8'h02);
    chk({15'h0, irq}, 16'h0001);
    wr(8'h30, 8'h02);
    rd(8'h30, 8'h00);
    chk({15'h0, irq}, 16'h0000);
    // Carrier and slow input clocks
    wr(8'h1e, 8'h00);
    pulse(3);
    wait_run(1'b0, 100);
    wr(8'h1e, 8'h01);
    pulse(3);
    repeat (100) @(posedge clk_in);
    wait_run(1'b1, 1);
    wait_run(1'b0, 6000);
    // Start at transmit end and stop on receive
    wr(8'h1e, 8'h91);
    pulse(5);
    wait_run(1'b1, 1);
    pulse(6);
    wait_run(1'b0, 1);
    wr(8'h1e, 8'h11);
    pulse(5);
    pulse(6);
    wait_run(1'b1, 1);
    pulse(4);
    wr(8'h1e, 8'h01);
    pulse(5);
    wait_run(1'b0, 1);
    // Trimming mode on oscillator edges
    wr(8'h1e, 8'ha1);
    @(posedge clk_in);
    low_frequency_oscillator <= 1'b1;
    wait_run(1'b1, 8);
    pulse(6);
    wait_run(1'b1, 1);
    low_frequency_oscillator <= 1'b0;
    repeat (6) @(posedge clk_in);
    low_frequency_oscillator <= 1'b1;
    wait_run(1'b0, 8);
    end_of_test();
  end
endmodule : reload_countdown_timer_test
